// File: design/dtt_map.svh
// register map, field positions, reset values and select codes of the dual timer
`ifndef DTT_MAP_SVH
`define DTT_MAP_SVH

`define DTT_ADDR_W          8
`define DTT_DATA_W          8

`define DTT_A_T0            8'h00
`define DTT_A_T1            8'h01
`define DTT_A_RUN           8'h02
`define DTT_A_CLK           8'h03
`define DTT_A_TOG           8'h04

`define DTT_RUN_T0_BIT      0
`define DTT_RUN_T1_BIT      1
`define DTT_CLK_T0_LSB      0
`define DTT_CLK_T1_LSB      2
`define DTT_CLK_MODE_BIT    4
`define DTT_TOG_CMD_LSB     0
`define DTT_TOG_INV_BIT     2
`define DTT_TOG_SRC_BIT     3

`define DTT_SEL_EXT         2'h0
`define DTT_SEL_T0MATCH     2'h0
`define DTT_SEL_DIV8        2'h1
`define DTT_SEL_DIV128      2'h2
`define DTT_SEL_DIV2048     2'h3

`define DTT_CMD_CLEAR       2'h0
`define DTT_CMD_SET         2'h1
`define DTT_CMD_INVERT      2'h2

`define DTT_BYTE_ZERO       8'h00
`define DTT_CNT_ONE         9'h001
`define DTT_SEL_RESET       2'h0

`endif

// File: design/dtt_pkg.sv
// shared types of the dual timer
package dtt_pkg;
    typedef logic [7:0] dtt_byte_t;
    typedef logic [1:0] dtt_sel_t;
endpackage

// File: design/dtt_cnt_if.sv
// signals between the timer top and one counter/comparator slice
`timescale 1ns/1ps
interface dtt_cnt_if;
    logic               tick;
    logic               run;
    logic               self_clr;
    logic               ext_clr;
    dtt_pkg::dtt_byte_t cmp;
    dtt_pkg::dtt_byte_t cnt;
    logic               hit;
    logic               ovf;

    modport ctl (output tick, output run, output self_clr, output ext_clr, output cmp,
                 input cnt, input hit, input ovf);
    modport cnt_side (input tick, input run, input self_clr, input ext_clr, input cmp,
                      output cnt, output hit, output ovf);
endinterface

// File: design/dtt_counter.sv
// one 8-bit up counter with its comparator
`timescale 1ns/1ps
`include "dtt_map.svh"
module dtt_counter (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst,
    input  wire logic   ce,
    // slice signals
    dtt_cnt_if.cnt_side c
);
    dtt_pkg::dtt_byte_t cnt_r;
    logic [8:0]         sum;

    assign sum   = {1'b0, cnt_r} + `DTT_CNT_ONE;
    assign c.cnt = cnt_r;
    assign c.ovf = c.tick & sum[8];
    // compare value read live, so a new value acts at once; zero means 256 counts
    // a stopped slice must not match, or a parked timer 1 would raise requests
    assign c.hit = c.tick & c.run &
                   ((c.cmp == `DTT_BYTE_ZERO) ? sum[8] : (sum[7:0] == c.cmp)); // RL18

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= `DTT_BYTE_ZERO;
        end else if (ce) begin
            if (!c.run || c.ext_clr || (c.hit && c.self_clr)) begin
                cnt_r <= `DTT_BYTE_ZERO; // RL9
            end else if (c.tick) begin
                cnt_r <= sum[7:0];
            end
        end
    end

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_CNT_STOP_CLEARS: assert property (ce && !c.run |=> cnt_r == `DTT_BYTE_ZERO) // RL9
        else $error("counter not cleared while stopped");
    AST_CNT_MATCH_CLEARS: assert property (ce && c.hit && c.self_clr |=> cnt_r == `DTT_BYTE_ZERO) // RL9
        else $error("counter not cleared on match");
endmodule

// File: design/dtt_top.sv
// dual 8-bit interval timer with shared toggle flip-flop and register port
//
// Contract
// RL1 - selected match inverts toggle, drives output pin
// RL2 - 8-bit mode: select 0 timer0, 1 timer1
// RL3 - software sets select to 1 when cascaded
// RL4 - select bit resets to zero
// RL5 - inversion enable gates match inversion, resets zero
// RL6 - software command clears, sets or inverts toggle
// RL7 - only timer pair owns the toggle
// RL8 - clock from div8, div128, div2048 taps, external
// RL9 - counter cleared when stopped or matched
// RL10 - count read is live, zero when stopped
// RL11 - stop both timers before changing mode
// RL12 - timer1 may count timer0 matches
// RL13 - dummy timer1 compare write when timer0 alone
// RL14 - select clock before starting the timer
// RL15 - toggle state and compares are unreadable
// RL16 - stop, program, enable interrupt, then start
// RL17 - match zeroes counter, raises irq, inverts toggle
// RL18 - zero compare matches on overflow, immediate
// RL19 - cascade clocks timer1 by timer0 overflow
// RL20 - software command wins over match inversion
`timescale 1ns/1ps
`include "dtt_map.svh"
module dtt_top (
    // clock, reset, enable
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    // register port
    input  wire logic [`DTT_ADDR_W-1:0]   reg_addr,
    input  wire logic [`DTT_DATA_W-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [`DTT_DATA_W-1:0]   reg_rdata,
    // time base taps and external count input
    input  wire logic                     base_tap_div8,
    input  wire logic                     base_tap_div128,
    input  wire logic                     base_tap_div2048,
    input  wire logic                     ext_count_in,
    // outputs
    output logic                          toggle_out_pin,
    output logic                          irq_timer_zero,
    output logic                          irq_timer_one
);
    dtt_pkg::dtt_byte_t compare_t0_r;
    dtt_pkg::dtt_byte_t compare_t1_r;
    logic               run_bit_t0_r;
    logic               run_bit_t1_r;
    dtt_pkg::dtt_sel_t  t0_clock_sel_r;
    dtt_pkg::dtt_sel_t  t1_clock_sel_r;
    logic               cascade_mode_bit_r;
    logic               toggle_inv_en_r;
    logic               toggle_src_sel_r;
    logic               toggle_ff_r;
    logic               toggle_ff_nxt;
    logic [`DTT_DATA_W-1:0] rdata_r;
    logic [`DTT_DATA_W-1:0] rdata_nxt;
    logic               irq0_r;
    logic               irq1_r;
    logic [3:0]         tap_prev_r;
    logic [3:0]         tap_now;
    logic [3:0]         tap_edge;
    logic [1:0]         tick;
    logic [1:0]         run;
    logic               wr_t0;
    logic               wr_t1;
    logic               wr_run;
    logic               wr_clk;
    logic               wr_tog;
    logic               match16;
    logic               match0;
    logic               match1;
    logic               inv_event;
    logic [1:0]         sw_cmd;

    dtt_cnt_if slice [2] ();

    assign wr_t0  = reg_wr && (reg_addr == `DTT_A_T0);
    assign wr_t1  = reg_wr && (reg_addr == `DTT_A_T1);
    assign wr_run = reg_wr && (reg_addr == `DTT_A_RUN);
    assign wr_clk = reg_wr && (reg_addr == `DTT_A_CLK);
    assign wr_tog = reg_wr && (reg_addr == `DTT_A_TOG);
    assign sw_cmd = reg_wdata[`DTT_TOG_CMD_LSB +: 2];

    // taps are counted on their rising edges; inputs are synchronous to core_clk
    assign tap_now  = {ext_count_in, base_tap_div2048, base_tap_div128, base_tap_div8};
    assign tap_edge = tap_now & ~tap_prev_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tap_prev_r <= 4'h0;
        end else if (ce) begin
            tap_prev_r <= tap_now;
        end
    end

    // timer 0 clock: external pin or a time base tap
    always_comb begin
        case (t0_clock_sel_r)
            `DTT_SEL_EXT:     tick[0] = tap_edge[3]; // RL8
            `DTT_SEL_DIV8:    tick[0] = tap_edge[0]; // RL8
            `DTT_SEL_DIV128:  tick[0] = tap_edge[1];
            `DTT_SEL_DIV2048: tick[0] = tap_edge[2];
            default:          tick[0] = 1'b0;
        endcase
    end

    // timer 1 clock: timer 0 match, a tap, or timer 0 overflow when cascaded
    always_comb begin
        if (cascade_mode_bit_r) begin
            tick[1] = slice[0].ovf; // RL19
        end else begin
            case (t1_clock_sel_r)
                `DTT_SEL_T0MATCH: tick[1] = slice[0].hit; // RL12
                `DTT_SEL_DIV8:    tick[1] = tap_edge[0]; // RL8
                `DTT_SEL_DIV128:  tick[1] = tap_edge[1];
                `DTT_SEL_DIV2048: tick[1] = tap_edge[2];
                default:          tick[1] = 1'b0;
            endcase
        end
    end

    assign run = {run_bit_t1_r, run_bit_t0_r};

    // in cascade the 16-bit match is timer 0 hitting while timer 1 sits at its compare
    assign match16 = slice[0].hit && (slice[1].cnt == compare_t1_r);
    assign match0  = !cascade_mode_bit_r && slice[0].hit;
    assign match1  = cascade_mode_bit_r ? match16 : slice[1].hit;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_slice
            assign slice[gi].tick     = tick[gi];
            assign slice[gi].run      = run[gi];
            assign slice[gi].self_clr = !cascade_mode_bit_r; // RL17
            assign slice[gi].ext_clr  = cascade_mode_bit_r && match16;
            assign slice[gi].cmp      = (gi == 0) ? compare_t0_r : compare_t1_r;
            dtt_counter u_cnt (
                .core_clk (core_clk),
                .rst      (rst),
                .ce       (ce),
                .c        (slice[gi].cnt_side)
            );
        end
    endgenerate

    // control registers; software keeps mode changes to stopped timers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            compare_t0_r <= `DTT_BYTE_ZERO;
            compare_t1_r <= `DTT_BYTE_ZERO;
        end else if (ce) begin
            if (wr_t0) begin
                compare_t0_r <= reg_wdata;
            end
            if (wr_t1) begin
                compare_t1_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_bit_t0_r       <= 1'b0;
            run_bit_t1_r       <= 1'b0;
            t0_clock_sel_r     <= `DTT_SEL_RESET;
            t1_clock_sel_r     <= `DTT_SEL_RESET;
            cascade_mode_bit_r <= 1'b0; // RL19
        end else if (ce) begin
            if (wr_run) begin
                run_bit_t0_r <= reg_wdata[`DTT_RUN_T0_BIT];
                run_bit_t1_r <= reg_wdata[`DTT_RUN_T1_BIT];
            end
            if (wr_clk) begin
                t0_clock_sel_r     <= reg_wdata[`DTT_CLK_T0_LSB +: 2];
                t1_clock_sel_r     <= reg_wdata[`DTT_CLK_T1_LSB +: 2];
                cascade_mode_bit_r <= reg_wdata[`DTT_CLK_MODE_BIT];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            toggle_inv_en_r  <= 1'b0; // RL5
            toggle_src_sel_r <= 1'b0; // RL4
        end else if (ce && wr_tog) begin
            toggle_inv_en_r  <= reg_wdata[`DTT_TOG_INV_BIT];
            toggle_src_sel_r <= reg_wdata[`DTT_TOG_SRC_BIT];
        end
    end

    // the one toggle flip-flop belongs to timers 0 and 1 only
    assign inv_event = toggle_inv_en_r && (toggle_src_sel_r ? match1 : match0); // RL1 RL2 RL5 RL7

    always_comb begin
        toggle_ff_nxt = toggle_ff_r;
        if (inv_event) begin
            toggle_ff_nxt = !toggle_ff_r; // RL17
        end
        // a software command replaces a same-cycle match inversion
        if (wr_tog) begin
            case (sw_cmd)
                `DTT_CMD_CLEAR:  toggle_ff_nxt = 1'b0; // RL6 RL20
                `DTT_CMD_SET:    toggle_ff_nxt = 1'b1; // RL6
                `DTT_CMD_INVERT: toggle_ff_nxt = !toggle_ff_r; // RL6
                default:         toggle_ff_nxt = toggle_ff_nxt;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            toggle_ff_r <= 1'b0;
        end else if (ce) begin
            toggle_ff_r <= toggle_ff_nxt; // RL1
        end
    end

    assign toggle_out_pin = toggle_ff_r; // RL1

    // interrupt requests are one-cycle pulses; timer 0 is silent when cascaded
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq0_r <= 1'b0;
            irq1_r <= 1'b0;
        end else if (ce) begin
            irq0_r <= match0; // RL17
            irq1_r <= match1; // RL17
        end
    end

    assign irq_timer_zero = irq0_r;
    assign irq_timer_one  = irq1_r;

    // read mux: compares and the toggle state are write-only
    always_comb begin
        rdata_nxt = `DTT_BYTE_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                `DTT_A_T0:  rdata_nxt = run_bit_t0_r ? slice[0].cnt : `DTT_BYTE_ZERO; // RL10
                `DTT_A_T1:  rdata_nxt = run_bit_t1_r ? slice[1].cnt : `DTT_BYTE_ZERO; // RL10
                `DTT_A_RUN: begin
                    rdata_nxt[`DTT_RUN_T0_BIT] = run_bit_t0_r;
                    rdata_nxt[`DTT_RUN_T1_BIT] = run_bit_t1_r;
                end
                `DTT_A_CLK: begin
                    rdata_nxt[`DTT_CLK_T0_LSB +: 2] = t0_clock_sel_r;
                    rdata_nxt[`DTT_CLK_T1_LSB +: 2] = t1_clock_sel_r;
                    rdata_nxt[`DTT_CLK_MODE_BIT]    = cascade_mode_bit_r;
                end
                `DTT_A_TOG: begin
                    rdata_nxt[`DTT_TOG_INV_BIT] = toggle_inv_en_r; // RL15
                    rdata_nxt[`DTT_TOG_SRC_BIT] = toggle_src_sel_r;
                end
                default:    rdata_nxt = `DTT_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= `DTT_BYTE_ZERO;
        end else if (ce) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_tog_wr(logic [1:0] cmd);
        ce && wr_tog && (sw_cmd == cmd);
    endsequence

    sequence s_match_inv;
        ce && inv_event && !wr_tog;
    endsequence

    AST_SRC_RESET: assert property ($past(rst) |-> !toggle_src_sel_r) // RL4
        else $error("source select not zero after reset");
    AST_INV_RESET: assert property ($past(rst) |-> !toggle_inv_en_r && !cascade_mode_bit_r) // RL5
        else $error("inversion enable or mode not zero after reset");
    AST_SW_CLEAR: assert property (s_tog_wr(`DTT_CMD_CLEAR) |=> !toggle_out_pin) // RL6
        else $error("software clear failed");
    AST_SW_SET: assert property (s_tog_wr(`DTT_CMD_SET) |=> toggle_out_pin) // RL6
        else $error("software set failed");
    AST_SW_INVERT: assert property (s_tog_wr(`DTT_CMD_INVERT) |=> toggle_out_pin != $past(toggle_out_pin)) // RL6
        else $error("software invert failed");
    AST_MATCH_INVERT: assert property (s_match_inv |=> toggle_out_pin != $past(toggle_out_pin)) // RL1
        else $error("match did not invert the toggle");
    AST_NO_INV_DISABLED: assert property (ce && !toggle_inv_en_r && !wr_tog |=> $stable(toggle_out_pin)) // RL5
        else $error("toggle changed with inversion disabled");
    AST_SRC_T0: assert property (ce && toggle_inv_en_r && !toggle_src_sel_r && match0 && !wr_tog
                                 |=> toggle_out_pin != $past(toggle_out_pin)) // RL2
        else $error("timer 0 match did not invert with select 0");
    AST_READ_ZERO: assert property (ce && reg_rd && reg_addr == `DTT_A_T0 && !run_bit_t0_r
                                    |=> reg_rdata == `DTT_BYTE_ZERO) // RL10
        else $error("stopped timer read not zero");
    AST_TOG_HIDDEN: assert property (ce && reg_rd && reg_addr == `DTT_A_TOG
                                     |=> reg_rdata[`DTT_TOG_CMD_LSB +: 2] == 2'h0) // RL15
        else $error("toggle state visible on read");
    AST_IRQ_ONE: assert property (ce && match1 |=> irq_timer_one) // RL17
        else $error("timer 1 match raised no request");
    AST_CASCADE_TICK: assert property (cascade_mode_bit_r && slice[0].ovf |-> tick[1]) // RL19
        else $error("cascade did not clock timer 1 by overflow");
endmodule

// File: tb/dtt_top_tb.sv
// self-checking bench for the dual timer with its shared toggle output
`timescale 1ns/1ps
`include "dtt_map.svh"
module dtt_top_tb;
    logic       core_clk;
    logic       rst;
    logic       ce;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    // tick sources indexed by the timer 0 clock select code
    logic [3:0] taps;
    logic       toggle_out_pin;
    logic       irq_timer_zero;
    logic       irq_timer_one;
    int         fails;
    int         compares;
    int         n0;
    int         n1;
    logic       exp_tog;
    logic [7:0] cval;
    logic [1:0] cmd_tab [5] = '{`DTT_CMD_SET, `DTT_CMD_INVERT, `DTT_CMD_INVERT, 2'h3,
                                `DTT_CMD_CLEAR};
    logic       tog_tab [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    dtt_top u_dtt_top (
        .core_clk        (core_clk),
        .rst             (rst),
        .ce              (ce),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .base_tap_div8   (taps[1]),
        .base_tap_div128 (taps[2]),
        .base_tap_div2048(taps[3]),
        .ext_count_in    (taps[0]),
        .toggle_out_pin  (toggle_out_pin),
        .irq_timer_zero  (irq_timer_zero),
        .irq_timer_one   (irq_timer_one)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // irq outputs are one-cycle pulses, so count them every edge
    always @(posedge core_clk) begin
        if (irq_timer_zero === 1'b1) n0 = n0 + 1;
        if (irq_timer_one === 1'b1) n1 = n1 + 1;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(what, exp, reg_rdata);
    endtask

    // each pulse is held long enough for the edge detector to see it
    task automatic tick(input int sel, input int n);
        repeat (n) begin
            @(posedge core_clk);
            taps[sel] <= 1'b1;
            repeat (2) @(posedge core_clk);
            taps[sel] <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
        @(negedge core_clk);
    endtask

    task automatic chk_out(input int e0, input int e1);
        chk("irq zero count", 8'(e0), 8'(n0));
        chk("irq one count", 8'(e1), 8'(n1));
        chk("toggle pin", {7'h0, exp_tog}, {7'h0, toggle_out_pin});
    endtask

    task automatic t0_period(input logic [1:0] sel, input logic [7:0] cmp, input logic inv);
        int per;
        per = (cmp == 8'h00) ? 256 : int'(cmp);
        wr(`DTT_A_RUN, 8'h00);
        wr(`DTT_A_CLK, {6'h0, sel});
        wr(`DTT_A_T0, cmp);
        wr(`DTT_A_T1, 8'h01);
        wr(`DTT_A_TOG, {5'h0, inv, `DTT_CMD_CLEAR});
        exp_tog = 1'b0;
        wr(`DTT_A_RUN, 8'h01);
        n0 = 0;
        n1 = 0;
        tick(sel, per - 1);
        rd(`DTT_A_T0, 8'(per - 1), "live count");
        chk_out(0, 0);
        tick(sel, 1);
        exp_tog = inv;
        chk_out(1, 0);
        rd(`DTT_A_T0, 8'h00, "count after match");
        tick(sel, 1);
        wr(`DTT_A_RUN, 8'h00);
        rd(`DTT_A_T0, 8'h00, "count stopped");
        wr(`DTT_A_RUN, 8'h01);
        rd(`DTT_A_T0, 8'h00, "count restarted");
        wr(`DTT_A_RUN, 8'h00);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the whole run needs a few thousand cycles
    initial begin
        #(20000 * 5);
        fails++;
        tally_and_finish();
    end

    initial begin
        rst       = 1'b1;
        ce        = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        taps      = 4'h0;
        fails     = 0;
        compares  = 0;
        n0        = 0;
        n1        = 0;
        exp_tog   = 1'b0;
        void'($urandom(61));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk_out(0, 0);
        rd(`DTT_A_RUN, 8'h00, "run after reset");
        rd(`DTT_A_CLK, 8'h00, "clock after reset");
        rd(`DTT_A_TOG, 8'h00, "toggle ctrl after reset");
        for (int i = 0; i < 5; i++) begin
            wr(`DTT_A_TOG, {6'h0, cmd_tab[i]});
            repeat (2) @(negedge core_clk);
            exp_tog = tog_tab[i];
            chk("toggle after command", {7'h0, exp_tog}, {7'h0, toggle_out_pin});
        end
        // a command written while the enable is low must be lost
        @(posedge core_clk);
        ce <= 1'b0;
        wr(`DTT_A_TOG, {6'h0, `DTT_CMD_SET});
        ce <= 1'b1;
        @(negedge core_clk);
        chk("toggle frozen by enable", {7'h0, exp_tog}, {7'h0, toggle_out_pin});
        wr(`DTT_A_TOG, 8'h0d);
        rd(`DTT_A_TOG, 8'h0c, "toggle ctrl readback");
        wr(`DTT_A_T0, 8'h05);
        rd(`DTT_A_T0, 8'h00, "compare not readable");
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00, "unmapped read");
        for (int s = 0; s < 4; s++) begin
            cval = 8'($urandom % 5 + 1);
            t0_period(2'(s), cval, s[0]);
        end
        t0_period(`DTT_SEL_DIV8, 8'h00, 1'b1);
        // timer 1 counts timer 0 matches, toggle follows timer 1 only
        wr(`DTT_A_CLK, 8'h01);
        wr(`DTT_A_T0, 8'h02);
        wr(`DTT_A_T1, 8'h02);
        wr(`DTT_A_TOG, 8'h0c);
        exp_tog = 1'b0;
        wr(`DTT_A_RUN, 8'h03);
        n0 = 0;
        n1 = 0;
        tick(1, 2);
        chk_out(1, 0);
        tick(1, 2);
        exp_tog = 1'b1;
        chk_out(2, 1);
        // cascade: stop both before the mode change
        wr(`DTT_A_RUN, 8'h00);
        wr(`DTT_A_CLK, 8'h11);
        wr(`DTT_A_T0, 8'h02);
        wr(`DTT_A_T1, 8'h01);
        wr(`DTT_A_TOG, 8'h0c);
        exp_tog = 1'b0;
        wr(`DTT_A_RUN, 8'h03);
        n0 = 0;
        n1 = 0;
        tick(1, 257);
        chk_out(0, 0);
        tick(1, 1);
        exp_tog = 1'b1;
        chk_out(0, 1);
        wr(`DTT_A_RUN, 8'h00);
        wr(`DTT_A_CLK, 8'h00);
        tally_and_finish();
    end
endmodule
